// file: psdt_top.sv
/*
 * Protection stage delay timer: register port, curve engine, stage
 * forcing, interrupt status and the operating timer.
 * Assumes measured current and pick-up arrive from logic on core_clk,
 * scaled in hundredths of nominal current, as the settings are.
 */
// Decided for this implementation: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module psdt_top
#(
	parameter int TICK_CYCLES = psdt_pkg::TICK_CYCLES_DEF
)
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        srst,
	// register port
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic [31:0]      regRdData,
	// measurement front end
	input  wire logic [15:0] measuredCurrent,
	input  wire logic        measuredValid,
	input  wire logic        pickupIn,
	// stage outputs
	output logic             stageStart,
	output logic             stageTrip,
	output logic             stageBlocked,
	output logic             irq
);
	import psdt_pkg::*;

	generate
		if (TICK_CYCLES < 2)
			$error("TICK_CYCLES must be at least 2");
	endgenerate

	// settings and state
	logic [7:0]    ctrl_r;
	logic [15:0]   dial_r;
	logic [15:0]   pickupSet_r;
	logic [15:0]   release_r;
	logic [2:0]    irqStat_r;
	logic [2:0]    irqMask_r;
	logic [2:0]    irqStat_nxt;
	logic [2:0]    irqEvents;
	logic [31:0]   delay_r;
	logic          delayValid_r;
	logic [15:0]   current_r;
	logic [31:0]   tickCnt_r;
	logic          tick_r;
	psdt_calc_type calc_r;
	psdt_calc_type calc_nxt;
	logic          divStart_r;
	logic [31:0]   divDividend_r;
	logic [31:0]   divDivisor_r;
	logic [31:0]   rdMux;

	// timer results
	logic          timerStart;
	logic          timerTrip;
	logic          timerRelEnd;
	logic [31:0]   opTime;

	psdt_div_if divIf ();

	// mantissa-linear log2 in Q16; good to a few percent, fine for grading
	function automatic logic [31:0] log2q(input logic [15:0] v);
		logic [4:0]  p;
		logic [31:0] sh;
		p = 5'h00;
		for (int i = 0; i < 16; i++)
			if (v[i])
				p = 5'(i);
		sh = {16'h0000, v} << (5'h10 - p);
		return {11'h000, p, sh[15:0]};
	endfunction

	// write and read decode
	logic wrCtrl, wrDial, wrPickup, wrRelease, wrMask, rdIrq;
	assign wrCtrl = regWr && regAddr == OFF_CTRL;
	assign wrDial = regWr && regAddr == OFF_DIAL;
	assign wrPickup = regWr && regAddr == OFF_PICKUP;
	assign wrRelease = regWr && regAddr == OFF_RELEASE;
	assign wrMask = regWr && regAddr == OFF_IRQ_MASK;
	assign rdIrq = regRd && regAddr == OFF_IRQ_STAT;

	// control fields
	logic           curveLog, delayedRel, clearAfter, contCalc, forceEn;
	psdt_force_type forceSt;
	assign curveLog = ctrl_r[CTL_LOG];
	assign delayedRel = ctrl_r[CTL_DELAYED];
	assign clearAfter = ctrl_r[CTL_CLEAR_AFTER];
	assign contCalc = ctrl_r[CTL_CONTINUE];
	assign forceEn = ctrl_r[CTL_FORCE_EN];
	assign forceSt = psdt_force_type'(ctrl_r[CTL_FORCE_LO +: 2]);

	// stage status: forced state ORed with the measured one
	logic stageStart_nxt, stageTrip_nxt, stageBlocked_nxt;
	assign stageStart_nxt = timerStart
		|| (forceEn && (forceSt == F_START || forceSt == F_TRIP));
	assign stageTrip_nxt = timerTrip || (forceEn && forceSt == F_TRIP);
	assign stageBlocked_nxt = forceEn && forceSt == F_BLOCKED;

	// sticky interrupt status; a new event beats the read clear
	assign irqEvents[IRQ_START] = stageStart_nxt && !stageStart;
	assign irqEvents[IRQ_TRIP] = stageTrip_nxt && !stageTrip;
	assign irqEvents[IRQ_RELEASE] = timerRelEnd;
	assign irqStat_nxt = (rdIrq ? 3'h0 : irqStat_r) | irqEvents;

	// dial clamped so the reciprocal dividend fits 32 bits
	logic [15:0] kEff, kMs;
	logic        inputsZero;
	assign kEff = (dial_r > K_MAX) ? K_MAX : dial_r;
	assign kMs = 16'(kEff * K_MS_PER_LSB);
	assign inputsZero = measuredCurrent == 16'h0000 || kEff == 16'h0000
		|| pickupSet_r == 16'h0000;

	// reciprocal denominator from the ratio quotient
	logic [63:0]        ratioProd;
	logic signed [63:0] denom;
	logic               denomPos;
	assign ratioProd = {32'h0000_0000, RECIP_B_Q16} * {32'h0000_0000, divIf.quotient};
	assign denom = $signed({32'h0000_0000, RECIP_A_Q16})
		- $signed({16'h0000, ratioProd[63:16]});
	assign denomPos = !denom[63] && denom != 64'h0000_0000_0000_0000;

	// logarithmic curve in one step
	logic signed [31:0] logL;
	logic signed [63:0] logProd;
	logic signed [63:0] logTime;
	logic               logNeg;
	logic [31:0]        logTimeU;
	assign logL = $signed(log2q(current_r) + LOG2_100_Q16 - log2q(kEff)
		- log2q(pickupSet_r));
	assign logProd = $signed({{32{logL[31]}}, logL})
		* $signed({32'h0000_0000, LOG_SLOPE_Q8});
	assign logTime = $signed({32'h0000_0000, LOG_C_MS}) - (logProd >>> 24);
	assign logNeg = logTime[63];
	assign logTimeU = logNeg ? 32'h0000_0000 : logTime[31:0];

	// curve engine sequencing; samples arriving mid-calculation are dropped
	always_comb
	begin
		calc_nxt = calc_r;
		case (calc_r)
			C_IDLE:
				if (measuredValid && !inputsZero)
					calc_nxt = curveLog ? C_LOG : C_RATIO;
			C_RATIO:
				if (divIf.done)
					calc_nxt = denomPos ? C_TIME : C_IDLE;
			C_TIME:
				if (divIf.done)
					calc_nxt = C_IDLE;
			C_LOG:
				calc_nxt = C_IDLE;
			default:
				calc_nxt = C_IDLE;
		endcase
	end

	// divider requests
	assign divIf.start = divStart_r;
	assign divIf.dividend = divDividend_r;
	assign divIf.divisor = divDivisor_r;

	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			calc_r <= C_IDLE;
			divStart_r <= 1'b0;
			divDividend_r <= 32'h0000_0000;
			divDivisor_r <= 32'h0000_0001;
			current_r <= 16'h0000;
		end
		else
		begin
			calc_r <= calc_nxt;
			divStart_r <= 1'b0;
			if (calc_r == C_IDLE && measuredValid && !inputsZero)
			begin
				current_r <= measuredCurrent;
				divStart_r <= !curveLog;
				divDividend_r <= {pickupSet_r, 16'h0000};
				divDivisor_r <= {16'h0000, measuredCurrent};
			end
			else if (calc_r == C_RATIO && divIf.done && denomPos)
			begin
				divStart_r <= 1'b1;
				divDividend_r <= {kMs, 16'h0000};
				divDivisor_r <= denom[31:0];
			end
		end
	end

	// computed delay; unreachable curves park at the maximum
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			delay_r <= DELAY_MAX;
			delayValid_r <= 1'b0;
		end
		else if (calc_r == C_IDLE && measuredValid && inputsZero)
		begin
			delay_r <= DELAY_MAX;
			delayValid_r <= 1'b1;
		end
		else if (calc_r == C_RATIO && divIf.done && !denomPos)
		begin
			delay_r <= DELAY_MAX;
			delayValid_r <= 1'b1;
		end
		else if (calc_r == C_TIME && divIf.done)
		begin
			delay_r <= divIf.quotient;
			delayValid_r <= 1'b1;
		end
		else if (calc_r == C_LOG)
		begin
			delay_r <= logTimeU;
			delayValid_r <= 1'b1;
		end
	end

	// millisecond tick for both timers
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			tickCnt_r <= 32'h0000_0000;
			tick_r <= 1'b0;
		end
		else
		begin
			tick_r <= tickCnt_r == 32'(TICK_CYCLES - 1);
			tickCnt_r <= (tickCnt_r == 32'(TICK_CYCLES - 1)) ? 32'h0000_0000
				: tickCnt_r + 32'h0000_0001;
		end
	end

	// settings registers
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			ctrl_r <= CTRL_RESET;
			dial_r <= DIAL_RESET;
			pickupSet_r <= PICKUP_RESET;
			release_r <= RELEASE_RESET;
			irqMask_r <= 3'h0;
		end
		else
		begin
			if (wrCtrl)
				ctrl_r <= regWrData[7:0];
			if (wrDial)
				dial_r <= regWrData[15:0];
			if (wrPickup)
				pickupSet_r <= regWrData[15:0];
			if (wrRelease)
				release_r <= regWrData[15:0];
			if (wrMask)
				irqMask_r <= regWrData[2:0];
		end
	end

	// read selection; unmapped addresses read zero
	always_comb
	begin
		if (regAddr == OFF_CTRL)
			rdMux = {24'h00_0000, ctrl_r};
		else if (regAddr == OFF_DIAL)
			rdMux = {16'h0000, dial_r};
		else if (regAddr == OFF_PICKUP)
			rdMux = {16'h0000, pickupSet_r};
		else if (regAddr == OFF_RELEASE)
			rdMux = {16'h0000, release_r};
		else if (regAddr == OFF_STATUS)
			rdMux = {27'h000_0000, calc_r != C_IDLE, delayValid_r, stageBlocked,
				stageTrip, stageStart};
		else if (regAddr == OFF_DELAY)
			rdMux = delay_r;
		else if (regAddr == OFF_OPTIME)
			rdMux = opTime;
		else if (regAddr == OFF_IRQ_STAT)
			rdMux = {29'h0000_0000, irqStat_r};
		else if (regAddr == OFF_IRQ_MASK)
			rdMux = {29'h0000_0000, irqMask_r};
		else
			rdMux = 32'h0000_0000;
	end

	// registered outputs
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			regRdData <= 32'h0000_0000;
			irqStat_r <= 3'h0;
			irq <= 1'b0;
			stageStart <= 1'b0;
			stageTrip <= 1'b0;
			stageBlocked <= 1'b0;
		end
		else
		begin
			regRdData <= regRd ? rdMux : 32'h0000_0000;
			irqStat_r <= irqStat_nxt;
			irq <= |(irqStat_nxt & irqMask_r);
			stageStart <= stageStart_nxt;
			stageTrip <= stageTrip_nxt;
			stageBlocked <= stageBlocked_nxt;
		end
	end

	psdt_divider u_div
	(
		.core_clk (core_clk),
		.srst     (srst),
		.div      (divIf)
	);

	psdt_op_timer u_timer
	(
		.core_clk          (core_clk),
		.srst              (srst),
		.tick              (tick_r),
		.pickup            (pickupIn),
		.delayedRelease    (delayedRel),
		.clearAfterRelease (clearAfter),
		.continueCalc      (contCalc),
		.delayValid        (delayValid_r),
		.releaseSteps      (release_r),
		.delayMs           (delay_r),
		.start             (timerStart),
		.trip              (timerTrip),
		.releaseEnd        (timerRelEnd),
		.opTime            (opTime)
	);

	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	sequence s_ratio_done;
		calc_r == C_RATIO && divIf.done && denomPos;
	endsequence
	sequence s_time_done;
		calc_r == C_TIME ##[1:40] (divIf.done && calc_r == C_TIME);
	endsequence
	a_recip_chain: assert property (s_ratio_done |=> s_time_done)
		else $error("reciprocal delay not completed");
	a_log_value: assert property (calc_r == C_LOG && !logNeg |=> delay_r == $past(logTimeU))
		else $error("log delay not loaded");
	a_log_instant: assert property (calc_r == C_LOG && logNeg
		|=> delay_r == 32'h0000_0000 && delayValid_r)
		else $error("negative log delay not instant");
	a_force_trip: assert property (forceEn && forceSt == F_TRIP |=> stageTrip && stageStart)
		else $error("forced trip not shown");
	a_measured_trip: assert property (timerTrip |=> stageTrip)
		else $error("measured trip masked");
	a_irq_read_clear: assert property (rdIrq && irqEvents == 3'h0 |=> irqStat_r == 3'h0)
		else $error("interrupt status not cleared by read");
endmodule
`default_nettype wire

// file: psdt_pkg.sv
/*
 * Shared constants for the protection stage delay timer: register map,
 * control field positions, curve coefficients, timing counts and types.
 * Assumes a 200 MHz core clock and settings scaled in hundredths.
 */
package psdt_pkg;
	// clock and time base
	localparam int CLK_PERIOD_PS = 5000;
	localparam int TICK_TIME_US = 1000;
	localparam int TICK_CYCLES_DEF = TICK_TIME_US * 1000000 / CLK_PERIOD_PS;
	localparam int REL_STEP_MS = 5;
	// register offsets (byte addresses)
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_DIAL = 8'h04;
	localparam logic [7:0] OFF_PICKUP = 8'h08;
	localparam logic [7:0] OFF_RELEASE = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_DELAY = 8'h14;
	localparam logic [7:0] OFF_OPTIME = 8'h18;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h1C;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h20;
	// control field positions and reset values
	localparam int CTL_LOG = 0;
	localparam int CTL_DELAYED = 1;
	localparam int CTL_CLEAR_AFTER = 2;
	localparam int CTL_CONTINUE = 3;
	localparam int CTL_FORCE_EN = 4;
	localparam int CTL_FORCE_LO = 5;
	localparam logic [7:0] CTRL_RESET = 8'h06;
	localparam logic [15:0] DIAL_RESET = 16'h0005;
	localparam logic [15:0] PICKUP_RESET = 16'h0078;
	localparam logic [15:0] RELEASE_RESET = 16'h000C;
	// interrupt bit positions
	localparam int IRQ_START = 0;
	localparam int IRQ_TRIP = 1;
	localparam int IRQ_RELEASE = 2;
	// curve coefficients, Q16 and Q8 fractions and milliseconds
	localparam logic [31:0] RECIP_A_Q16 = 32'h0000_56C9;
	localparam logic [31:0] RECIP_B_Q16 = 32'h0000_3C6B;
	localparam logic [15:0] K_MS_PER_LSB = 16'h000A;
	localparam logic [15:0] K_MAX = 16'h09C4;
	localparam logic [31:0] LOG_C_MS = 32'h0000_16A8;
	localparam logic [31:0] LOG_SLOPE_Q8 = 32'h0003_A7C0;
	localparam logic [31:0] LOG2_100_Q16 = 32'h0006_A4D4;
	localparam logic [31:0] DELAY_MAX = 32'hFFFF_FFFF;
	typedef enum logic [1:0] {
		F_NORMAL = 2'h0,
		F_START = 2'h1,
		F_TRIP = 2'h2,
		F_BLOCKED = 2'h3
	} psdt_force_type;
	typedef enum logic [3:0] {
		C_IDLE = 4'h1,
		C_RATIO = 4'h2,
		C_TIME = 4'h4,
		C_LOG = 4'h8
	} psdt_calc_type;
endpackage

// file: psdt_div_if.sv
/*
 * Request and answer of the unsigned divider used by the curve engine.
 * Assumes both ends share core_clk; start is a one-cycle pulse.
 */
`timescale 1ns/1ps
`default_nettype none
interface psdt_div_if;
	logic        start;
	logic [31:0] dividend;
	logic [31:0] divisor;
	logic [31:0] quotient;
	logic        done;
	modport master (output start, dividend, divisor, input quotient, done);
	modport slave (input start, dividend, divisor, output quotient, done);
endinterface
`default_nettype wire

// file: psdt_divider.sv
/*
 * Restoring 32-bit unsigned divider, one quotient bit per clock.
 * Assumes the requester never passes a zero divisor.
 */
`timescale 1ns/1ps
`default_nettype none
module psdt_divider
(
	// clock and reset
	input  wire logic  core_clk,
	input  wire logic  srst,
	// request and answer
	psdt_div_if.slave  div
);
	import psdt_pkg::*;
	logic [32:0] rem_r;
	logic [31:0] quo_r;
	logic [31:0] den_r;
	logic [5:0]  cnt_r;
	logic        done_r;
	logic [32:0] remShift;
	logic        fits;

	// one restoring step
	assign remShift = {rem_r[31:0], quo_r[31]};
	assign fits = remShift >= {1'b0, den_r};
	assign div.quotient = quo_r;
	assign div.done = done_r;

	// a new start simply restarts any division in flight
	always_ff @(posedge core_clk)
	begin
		done_r <= 1'b0;
		if (srst)
		begin
			rem_r <= 33'h0_0000_0000;
			quo_r <= 32'h0000_0000;
			den_r <= 32'h0000_0000;
			cnt_r <= 6'h00;
		end
		else if (div.start)
		begin
			rem_r <= 33'h0_0000_0000;
			quo_r <= div.dividend;
			den_r <= div.divisor;
			cnt_r <= 6'h20;
		end
		else if (cnt_r != 6'h00)
		begin
			rem_r <= fits ? remShift - {1'b0, den_r} : remShift;
			quo_r <= {quo_r[30:0], fits};
			cnt_r <= cnt_r - 6'h01;
			done_r <= cnt_r == 6'h01;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	a_div_bounded: assert property (div.start |-> ##[1:40] div.done)
		else $error("divider did not finish in time");
endmodule
`default_nettype wire

// file: psdt_op_timer.sv
/*
 * Operating timer and release timer of one stage, counted in ms ticks.
 * Assumes pickup and settings come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module psdt_op_timer
(
	// clock and reset
	input  wire logic        core_clk,
	input  wire logic        srst,
	// pick-up, time base and settings
	input  wire logic        tick,
	input  wire logic        pickup,
	input  wire logic        delayedRelease,
	input  wire logic        clearAfterRelease,
	input  wire logic        continueCalc,
	input  wire logic        delayValid,
	input  wire logic [15:0] releaseSteps,
	input  wire logic [31:0] delayMs,
	// results
	output logic             start,
	output logic             trip,
	output logic             releaseEnd,
	output logic [31:0]      opTime
);
	import psdt_pkg::*;
	logic        pickupD_r;
	logic        releasing_r;
	logic        releasing_nxt;
	logic [31:0] relCnt_r;
	logic [31:0] relLimit;
	logic [31:0] opTime_nxt;
	logic        dropNow;
	logic        relDone;
	logic        inRelease;

	// release length in ms from 5 ms steps
	assign relLimit = 32'({16'h0000, releaseSteps} * REL_STEP_MS);
	assign dropNow = pickupD_r && !pickup;
	assign relDone = releasing_r && !pickup && relCnt_r >= relLimit;
	assign inRelease = (releasing_r || dropNow) && !pickup;
	assign releasing_nxt = pickup ? 1'b0 : dropNow ? 1'b1 : relDone ? 1'b0 : releasing_r;

	// operating time across pick-up, drop and release
	always_comb
	begin
		opTime_nxt = opTime;
		if (pickup)
			opTime_nxt = (tick && opTime != DELAY_MAX) ? opTime + 32'h0000_0001 : opTime;
		else if (dropNow && !clearAfterRelease && !continueCalc)
			opTime_nxt = 32'h0000_0000;
		else if (relDone)
			opTime_nxt = 32'h0000_0000;
		else if (inRelease && continueCalc && clearAfterRelease)
			opTime_nxt = (tick && opTime != 32'h0000_0000) ? opTime - 32'h0000_0001 : opTime;
		else if (inRelease && continueCalc)
			opTime_nxt = (tick && opTime != DELAY_MAX) ? opTime + 32'h0000_0001 : opTime;
		else if (inRelease)
			opTime_nxt = opTime;
		else
			opTime_nxt = 32'h0000_0000;
	end

	// release counter restarts on every new drop
	always_ff @(posedge core_clk)
	begin
		if (srst)
		begin
			pickupD_r <= 1'b0;
			releasing_r <= 1'b0;
			relCnt_r <= 32'h0000_0000;
			opTime <= 32'h0000_0000;
			start <= 1'b0;
			trip <= 1'b0;
			releaseEnd <= 1'b0;
		end
		else
		begin
			pickupD_r <= pickup;
			releasing_r <= releasing_nxt;
			relCnt_r <= (pickup || dropNow) ? 32'h0000_0000 :
				(releasing_r && tick) ? relCnt_r + 32'h0000_0001 : relCnt_r;
			opTime <= opTime_nxt;
			start <= pickup || (delayedRelease && releasing_nxt);
			trip <= pickup && (trip || (delayValid && opTime >= delayMs));
			releaseEnd <= relDone;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (srst);
	sequence s_drop;
		pickupD_r && !pickup;
	endsequence
	a_start_fast_drop: assert property (s_drop and !delayedRelease |=> !start)
		else $error("start held without delayed release");
	a_start_held: assert property (s_drop and delayedRelease |=> start [*2])
		else $error("start not held after drop");
	a_trip_needs_pickup: assert property ($rose(trip) |-> $past(pickup))
		else $error("trip without active pick-up");
	a_trip_at_delay: assert property (pickup && delayValid && opTime >= delayMs |=> trip)
		else $error("trip missed at delay");
	a_clear_on_drop: assert property (s_drop and !clearAfterRelease && !continueCalc
		|=> opTime == 32'h0000_0000)
		else $error("timer not cleared at drop");
	a_hold_release: assert property (inRelease && !relDone && clearAfterRelease && !continueCalc
		|=> opTime == $past(opTime))
		else $error("timer moved while frozen");
	a_count_down: assert property (inRelease && !relDone && clearAfterRelease && continueCalc
		&& tick && opTime != 32'h0000_0000 |=> opTime == $past(opTime) - 32'h0000_0001)
		else $error("timer did not count down");
	a_keep_running: assert property (inRelease && !relDone && !clearAfterRelease && continueCalc
		&& tick && opTime != DELAY_MAX |=> opTime == $past(opTime) + 32'h0000_0001)
		else $error("timer stopped in release");
endmodule
`default_nettype wire

// file: psdt_front_model.sv
/*
 * Front end model: measured current samples and the pick-up level.
 * Assumes the bench calls its tasks from the core_clk domain.
 */
`timescale 1ns/1ps
`default_nettype none
module psdt_front_model
(
	// clock
	input  wire logic   core_clk,
	// measurement outputs
	output logic [15:0] measuredCurrent,
	output logic        measuredValid,
	output logic        pickupIn
);
	// quiet values at time zero
	initial
	begin
		measuredCurrent = 16'h0000;
		measuredValid = 1'b0;
		pickupIn = 1'b0;
	end
	// one-cycle valid; idle bus shows the inverse so stale data never matches
	task automatic sample(input logic [15:0] cur);
		@(posedge core_clk);
		measuredCurrent <= cur;
		measuredValid <= 1'b1;
		@(posedge core_clk);
		measuredValid <= 1'b0;
		measuredCurrent <= ~cur;
	endtask
	// comparator level, changed just after an edge
	task automatic level(input logic v);
		@(posedge core_clk);
		pickupIn <= v;
	endtask
endmodule
`default_nettype wire

// file: tb_top.sv
/*
 * Self-checking bench for the stage delay timer top.
 * Assumes a fast tick of 20 cycles, so one timer ms is 20 clocks.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import psdt_pkg::*;
	logic        core_clk;
	logic        srst;
	logic        regWr;
	logic        regRd;
	logic [7:0]  regAddr;
	logic [31:0] regWrData;
	logic [31:0] regRdData;
	logic [15:0] measuredCurrent;
	logic        measuredValid;
	logic        pickupIn;
	logic        stageStart;
	logic        stageTrip;
	logic        stageBlocked;
	logic        irq;
	int          badCount = 0;
	int          nTests = 0;
	psdt_top #(.TICK_CYCLES(20)) dut (.core_clk(core_clk), .srst(srst), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.measuredCurrent(measuredCurrent), .measuredValid(measuredValid),
		.pickupIn(pickupIn), .stageStart(stageStart), .stageTrip(stageTrip),
		.stageBlocked(stageBlocked), .irq(irq));
	psdt_front_model fe (.core_clk(core_clk), .measuredCurrent(measuredCurrent),
		.measuredValid(measuredValid), .pickupIn(pickupIn));
	// 200 MHz clock
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	// verdict and end of run
	task automatic results;
		if (badCount == 0 && nTests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// range compare on a design word
	task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
		nTests++;
		if (((got >= lo) && (got <= hi)) !== 1'b1)
		begin
			badCount++;
			$display("[ERR] %0t got %0h want %0h..%0h", $time, got, lo, hi);
		end
	endtask
	// compare of one output flag; the caller lets the edge settle first
	task automatic chkb(input logic got, input logic exp);
		chk(32'(got), 32'(exp), 32'(exp));
	endtask
	// register write, one strobe cycle
	task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask
	// register read, data taken in the one cycle it stands
	task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		#1 d = regRdData;
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
		logic [31:0] d;
		rdReg(a, d);
		chk(d, lo, hi);
	endtask
	// one sample, then poll busy under a bound
	task automatic calc(input logic [15:0] cur);
		logic [31:0] s;
		fe.sample(cur);
		repeat (3) @(posedge core_clk);
		for (int i = 0; i < 100; i++)
		begin
			rdReg(OFF_STATUS, s);
			if (s[4] === 1'b0)
				break;
		end
	endtask
	task automatic t_reset;
		rdChk(OFF_CTRL, 32'h0000_0006, 32'h0000_0006);
		rdChk(OFF_DIAL, 32'h0000_0005, 32'h0000_0005);
		rdChk(OFF_PICKUP, 32'h0000_0078, 32'h0000_0078);
		rdChk(OFF_RELEASE, 32'h0000_000C, 32'h0000_000C);
		rdChk(OFF_DELAY, DELAY_MAX, DELAY_MAX);
		wrReg(8'h24, 32'hFFFF_FFFF);
		rdChk(8'h24, 32'h0000_0000, 32'h0000_0000);
	endtask
	// k 1.00, setting 1.00, current 2.00 on both curves
	task automatic t_curves;
		wrReg(OFF_CTRL, 32'h0000_0007);
		wrReg(OFF_DIAL, 32'h0000_0064);
		wrReg(OFF_PICKUP, 32'h0000_0064);
		calc(16'h00C8);
		rdChk(OFF_DELAY, 32'h0000_126A, 32'h0000_1396);
		wrReg(OFF_CTRL, 32'h0000_0006);
		calc(16'h00C8);
		rdChk(OFF_DELAY, 32'h0000_1153, 32'h0000_1207);
		// current half the setting: denominator not positive, delay parks at the maximum
		calc(16'h0032);
		rdChk(OFF_DELAY, DELAY_MAX, DELAY_MAX);
	endtask
	// negative log delay, so trip at once; start and trip events raise irq
	task automatic t_trip;
		logic [31:0] d;
		wrReg(OFF_IRQ_MASK, 32'h0000_0003);
		wrReg(OFF_CTRL, 32'h0000_0001);
		wrReg(OFF_DIAL, 32'h0000_0005);
		calc(16'h07D0);
		rdChk(OFF_DELAY, 32'h0000_0000, 32'h0000_0000);
		fe.level(1'b1);
		repeat (2) @(posedge core_clk);
		#1 chkb(stageStart, 1'b1);
		for (int i = 0; i < 50 && stageTrip !== 1'b1; i++)
			@(posedge core_clk);
		#1 chkb(stageTrip, 1'b1);
		chkb(irq, 1'b1);
		rdReg(OFF_IRQ_STAT, d);
		chk(d & 32'h0000_0003, 32'h0000_0003, 32'h0000_0003);
		rdChk(OFF_IRQ_STAT, 32'h0000_0000, 32'h0000_0000);
		chkb(irq, 1'b0);
		fe.level(1'b0);
		repeat (2) @(posedge core_clk);
		#1 chkb(stageStart, 1'b0);
	endtask
	// 20 ms picked up, then watch the timer through a 20 ms release
	task automatic relMode(input logic [31:0] ctrl, input int kind);
		logic [31:0] a;
		logic [31:0] b;
		wrReg(OFF_CTRL, ctrl);
		fe.level(1'b1);
		repeat (400) @(posedge core_clk);
		fe.level(1'b0);
		repeat (5) @(posedge core_clk);
		rdReg(OFF_OPTIME, a);
		chkb(stageStart, 1'b1);
		repeat (100) @(posedge core_clk);
		rdReg(OFF_OPTIME, b);
		case (kind)
			0: chk(a, 32'h0000_0000, 32'h0000_0000);
			1:
			begin
				chk(a, 32'h0000_0013, 32'h0000_0015);
				chk(b - a + 32'h0000_000F, 32'h0000_000F, 32'h0000_000F);
			end
			2: chk(a - b, 32'h0000_0003, 32'h0000_0008);
			default: chk(b - a, 32'h0000_0003, 32'h0000_0008);
		endcase
		repeat (500) @(posedge core_clk);
		rdChk(OFF_OPTIME, 32'h0000_0000, 32'h0000_0000);
		chkb(stageStart, 1'b0);
	endtask
	task automatic t_release;
		logic [31:0] modes [4] = '{32'h0000_0002, 32'h0000_0006, 32'h0000_000E, 32'h0000_000A};
		wrReg(OFF_RELEASE, 32'h0000_0004);
		wrReg(OFF_DIAL, 32'h0000_0064);
		// zero current parks the delay at the maximum
		calc(16'h0000);
		rdChk(OFF_DELAY, DELAY_MAX, DELAY_MAX);
		calc(16'h00C8);
		for (int k = 0; k < 4; k++)
			relMode(modes[k], k);
	endtask
	// every forced status, then measured pick-up while forcing
	task automatic t_force;
		logic [2:0] e;
		for (int i = 0; i < 4; i++)
		begin
			wrReg(OFF_CTRL, 32'h0000_0010 | (32'(i) << 5));
			// a forced trip shows start beside trip, as a real trip does
			e = (i == 0) ? 3'h0 : (i == 1) ? 3'h4 : (i == 2) ? 3'h6 : 3'h1;
			repeat (1) @(posedge core_clk);
			#1 chk(32'({stageStart, stageTrip, stageBlocked}), 32'(e), 32'(e));
		end
		wrReg(OFF_CTRL, 32'h0000_0010);
		fe.level(1'b1);
		repeat (2) @(posedge core_clk);
		#1 chkb(stageStart, 1'b1);
		fe.level(1'b0);
		wrReg(OFF_CTRL, 32'h0000_0000);
	endtask
	// main sequence
	initial
	begin
		srst = 1'b1;
		regWr = 1'b0;
		regRd = 1'b0;
		regAddr = 8'h00;
		regWrData = 32'h0000_0000;
		repeat (6) @(posedge core_clk);
		srst <= 1'b0;
		t_reset();
		t_curves();
		t_trip();
		t_release();
		t_force();
		results();
	end
	// whole run needs about 4400 cycles; this is more than thirteen times that
	initial
	begin
		#300_000;
		badCount++;
		results();
	end
endmodule
`default_nettype wire
